// ---- hdl/bldr_config_regs.sv ----
// configuration register bank for slow start, outlet rise limit, anticondensation and outdoor reset curves
`timescale 1ns/1ps

module bldr_config_regs
	import bldr_pkg::*;
(
	input  wire logic                  clk_i,
	input  wire logic                  reset_n_i,
	input  wire bldr_pkg::bldr_req_s   req_i,
	output bldr_pkg::bldr_rsp_s        rsp_o,
	input  wire logic                  central_heat_pump_request_i,
	input  wire logic                  central_heat_anticond_active_i,
	input  wire logic                  domestic_hot_water_pump_request_i,
	input  wire logic                  domestic_hot_water_anticond_active_i,
	output logic                       central_heat_pump_o,
	output logic                       domestic_hot_water_pump_o,
	output logic [15:0]                slow_start_temperature_o,
	output logic                       outlet_rise_limit_on_o,
	output logic [15:0]                outlet_rise_rate_o,
	output logic [15:0]                outlet_rise_delay_o,
	output logic                       outlet_rise_delay_configured_o,
	output logic                       central_heat_anticond_on_o,
	output logic [15:0]                central_heat_anticond_temperature_o,
	output logic                       domestic_hot_water_anticond_on_o,
	output logic [15:0]                domestic_hot_water_anticond_temperature_o,
	output logic [4:0]                 anticond_precedence_o,
	output bldr_pkg::bldr_curve_s      central_heat_curve_o,
	output logic [15:0]                central_heat_boost_time_o,
	output logic [15:0]                central_heat_boost_ceiling_o,
	output bldr_pkg::bldr_curve_s      group_curve_o
);
	import bldr_pkg::*;

	// ==========================================================
	// value checks per word kind
	function automatic logic value_ok(input bldr_kind_e kind, input logic [15:0] v);
		logic ok;
		ok = 1'b0;
		unique case (kind)
			// signed tenths; anything outside the span is refused, not clipped
			BLDR_K_TEMP:  ok = ($signed(v) >= BLDR_TEMP_MIN) && ($signed(v) <= BLDR_TEMP_MAX);
			BLDR_K_FLAG:  ok = (v <= BLDR_FLAG_MAX);
			BLDR_K_SECS:  ok = (v <= BLDR_SECS_MAX);
			BLDR_K_DELAY: ok = (v <= BLDR_SECS_MAX) || (v == BLDR_NOT_CONFIGURED);
			BLDR_K_MAP:   ok = 1'b1;
			BLDR_K_RAW:   ok = 1'b1;
		endcase
		return ok;
	endfunction

	bldr_state_s q;
	bldr_state_s d;

	// ==========================================================
	// address decode, one comparator per word
	logic [BLDR_SLOTS-1:0] hit;
	logic [BLDR_SLOTS-1:0] legal;

	for (genvar i = 0; i < BLDR_SLOTS; i++) begin : g_slot
		assign hit[i]   = (req_i.addr == BLDR_SLOT_ADDR[i]);
		assign legal[i] = value_ok(BLDR_SLOT_KIND[i], req_i.wdata);
	end

	// ==========================================================
	// next state
	always_comb begin
		logic [15:0] rd_word;
		logic        wr_ok;
		rd_word = 16'h0000;
		wr_ok   = 1'b0;
		d       = q;
		for (int unsigned k = 0; k < BLDR_SLOTS; k++) begin
			if (hit[k]) begin
				rd_word = q.word[k];
				wr_ok   = legal[k];
			end
		end
		d.rsp.ack     = req_i.rd | req_i.wr;
		d.rsp.refused = 1'b0;
		d.rsp.rdata   = 16'h0000;
		if (req_i.rd) begin
			d.rsp.rdata = (hit != '0) ? rd_word : 16'h0000;
		end
		if (req_i.wr && !req_i.rd) begin
			if (hit != '0) begin
				d.rsp.refused = ~wr_ok;
			end
			for (int unsigned k = 0; k < BLDR_SLOTS; k++) begin
				if (hit[k] && wr_ok) begin
					if (BLDR_SLOT_KIND[k] == BLDR_K_MAP) begin
						d.word[k] = req_i.wdata & BLDR_MAP_MASK;
					end else begin
						d.word[k] = req_i.wdata;
					end
				end
			end
		end
		d.heat_pump = central_heat_pump_request_i
			& ~(q.word[BLDR_S_HON][0] & q.word[BLDR_S_HPUMP][0] & central_heat_anticond_active_i);
		d.water_pump = domestic_hot_water_pump_request_i
			& ~(q.word[BLDR_S_WON][0] & q.word[BLDR_S_WPUMP][0] & domestic_hot_water_anticond_active_i);
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			q                   <= '0;
			q.word[BLDR_S_RDLY] <= BLDR_NOT_CONFIGURED;
		end else begin
			q <= d;
		end
	end

	// ==========================================================
	// outputs, all straight from flip-flops except the delay-configured flag, which compares the stored delay word
	assign rsp_o                  = q.rsp;
	assign central_heat_pump_o    = q.heat_pump;
	assign domestic_hot_water_pump_o = q.water_pump;
	assign slow_start_temperature_o  = q.word[BLDR_S_SLOW];
	assign outlet_rise_limit_on_o    = q.word[BLDR_S_RON][0];
	assign outlet_rise_rate_o        = q.word[BLDR_S_RRATE];
	assign outlet_rise_delay_o       = q.word[BLDR_S_RDLY];
	assign outlet_rise_delay_configured_o = (q.word[BLDR_S_RDLY] != BLDR_NOT_CONFIGURED);
	assign central_heat_anticond_on_o          = q.word[BLDR_S_HON][0];
	assign central_heat_anticond_temperature_o = q.word[BLDR_S_HTEMP];
	assign domestic_hot_water_anticond_on_o    = q.word[BLDR_S_WON][0];
	assign domestic_hot_water_anticond_temperature_o = q.word[BLDR_S_WTEMP];
	assign anticond_precedence_o  = q.word[BLDR_S_MAP][4:0];
	// heat curve incl. minimum water word
	assign central_heat_curve_o.outdoor_high = q.word[BLDR_S_HCURVE];
	assign central_heat_curve_o.outdoor_low  = q.word[BLDR_S_HCURVE+1];
	assign central_heat_curve_o.water_low    = q.word[BLDR_S_HCURVE+2];
	assign central_heat_boost_time_o    = q.word[BLDR_S_BTIME];
	assign central_heat_boost_ceiling_o = q.word[BLDR_S_BCEIL];
	assign group_curve_o.outdoor_high = q.word[BLDR_S_GCURVE];
	assign group_curve_o.outdoor_low  = q.word[BLDR_S_GCURVE+1];
	assign group_curve_o.water_low    = q.word[BLDR_S_GCURVE+2];

	// ==========================================================
	// assertions
	sequence s_heat_force;
		central_heat_anticond_on_o && q.word[BLDR_S_HPUMP][0] && central_heat_anticond_active_i;
	endsequence

	sequence s_water_force;
		domestic_hot_water_anticond_on_o && q.word[BLDR_S_WPUMP][0] && domestic_hot_water_anticond_active_i;
	endsequence

	sequence s_write(logic [15:0] a);
		req_i.wr && !req_i.rd && (req_i.addr == a);
	endsequence

	a_answer_next: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(req_i.rd || req_i.wr) |=> rsp_o.ack ##1 !(rsp_o.ack && !$past(req_i.rd || req_i.wr)))
		else $error("request not answered exactly one cycle later");

	a_rise_switch: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		s_write(BLDR_ADDR_OUTLET_RISE_LIMIT_ON) && req_i.wdata <= BLDR_FLAG_MAX
		|=> !rsp_o.refused && (outlet_rise_limit_on_o == $past(req_i.wdata[0])))
		else $error("rise limit enable did not follow its word");

	a_delay_range: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		s_write(BLDR_ADDR_OUTLET_RISE_DELAY) && req_i.wdata > BLDR_SECS_MAX && req_i.wdata != BLDR_NOT_CONFIGURED
		|=> rsp_o.refused && $stable(outlet_rise_delay_o))
		else $error("rise delay above range was stored");

	a_delay_unset: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		s_write(BLDR_ADDR_OUTLET_RISE_DELAY) && req_i.wdata == BLDR_NOT_CONFIGURED
		|=> !outlet_rise_delay_configured_o && !rsp_o.refused)
		else $error("unconfigured delay marker mishandled");

	a_heat_pump: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		s_heat_force |=> !central_heat_pump_o)
		else $error("central heat pump not forced off");

	a_water_pump: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		s_water_force |=> !domestic_hot_water_pump_o)
		else $error("hot water pump not held off");

	a_map_upper: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		req_i.rd && req_i.addr == BLDR_ADDR_ANTICOND_PRECEDENCE_MAP |=> rsp_o.rdata[15:5] == 11'h000)
		else $error("reserved precedence bits read nonzero");

	a_temp_range: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		s_write(BLDR_ADDR_HEAT_CURVE_WATER_LOW) && $signed(req_i.wdata) < BLDR_TEMP_MIN
		|=> rsp_o.refused && $stable(central_heat_curve_o.water_low))
		else $error("temperature below range was stored");

	a_boost_range: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		s_write(BLDR_ADDR_HEAT_CURVE_BOOST_TIME) && req_i.wdata > BLDR_SECS_MAX |=> rsp_o.refused)
		else $error("boost time above range accepted");

	a_group_store: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		s_write(BLDR_ADDR_GROUP_CURVE_WATER_LOW) && $signed(req_i.wdata) >= BLDR_TEMP_MIN
		&& $signed(req_i.wdata) <= BLDR_TEMP_MAX |=> group_curve_o.water_low == $past(req_i.wdata))
		else $error("lead-lag water word not stored");

	a_negative_temp: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		s_write(BLDR_ADDR_SLOW_START_TEMPERATURE) && req_i.wdata == BLDR_TEMP_MIN
		|=> !rsp_o.refused ##1 slow_start_temperature_o == BLDR_TEMP_MIN || $past(req_i.wr))
		else $error("minus forty degrees not accepted");

	a_reserved_zero: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(req_i.rd || req_i.wr) && hit == '0 |=> rsp_o.rdata == 16'h0000 && !rsp_o.refused && $stable(q.word))
		else $error("reserved address had an effect");

endmodule

// ---- hdl/bldr_pkg.sv ----
// constants, types and register map of the boiler limit and outdoor reset configuration bank
package bldr_pkg;

	// ==========================================================
	// register map
	localparam int unsigned BLDR_SLOTS = 19;

	localparam logic [15:0] BLDR_ADDR_SLOW_START_TEMPERATURE     = 16'h01E0;
	localparam logic [15:0] BLDR_ADDR_OUTLET_RISE_LIMIT_ON       = 16'h01E1;
	localparam logic [15:0] BLDR_ADDR_OUTLET_RISE_RATE           = 16'h01E2;
	localparam logic [15:0] BLDR_ADDR_OUTLET_RISE_DELAY          = 16'h01E3;
	localparam logic [15:0] BLDR_ADDR_HEAT_ANTICOND_ON           = 16'h01F0;
	localparam logic [15:0] BLDR_ADDR_HEAT_ANTICOND_TEMPERATURE  = 16'h01F1;
	localparam logic [15:0] BLDR_ADDR_HEAT_ANTICOND_PUMP_OFF     = 16'h01F2;
	localparam logic [15:0] BLDR_ADDR_WATER_ANTICOND_ON          = 16'h01F3;
	localparam logic [15:0] BLDR_ADDR_WATER_ANTICOND_TEMPERATURE = 16'h01F4;
	localparam logic [15:0] BLDR_ADDR_WATER_ANTICOND_PUMP_OFF    = 16'h01F5;
	localparam logic [15:0] BLDR_ADDR_ANTICOND_PRECEDENCE_MAP    = 16'h01F6;
	localparam logic [15:0] BLDR_ADDR_HEAT_CURVE_OUTDOOR_HIGH    = 16'h0200;
	localparam logic [15:0] BLDR_ADDR_HEAT_CURVE_OUTDOOR_LOW     = 16'h0201;
	localparam logic [15:0] BLDR_ADDR_HEAT_CURVE_WATER_LOW       = 16'h0202;
	localparam logic [15:0] BLDR_ADDR_HEAT_CURVE_BOOST_TIME      = 16'h0203;
	localparam logic [15:0] BLDR_ADDR_HEAT_CURVE_BOOST_CEILING   = 16'h0204;
	localparam logic [15:0] BLDR_ADDR_GROUP_CURVE_OUTDOOR_HIGH   = 16'h0205;
	localparam logic [15:0] BLDR_ADDR_GROUP_CURVE_OUTDOOR_LOW    = 16'h0206;
	localparam logic [15:0] BLDR_ADDR_GROUP_CURVE_WATER_LOW      = 16'h0207;

	// ==========================================================
	// value checks
	typedef enum logic [5:0] {
		BLDR_K_TEMP  = 6'b00_0001,
		BLDR_K_FLAG  = 6'b00_0010,
		BLDR_K_SECS  = 6'b00_0100,
		BLDR_K_DELAY = 6'b00_1000,
		BLDR_K_MAP   = 6'b01_0000,
		BLDR_K_RAW   = 6'b10_0000
	} bldr_kind_e;

	localparam logic signed [15:0] BLDR_TEMP_MIN      = 16'hFE70;
	localparam logic signed [15:0] BLDR_TEMP_MAX      = 16'h0514;
	localparam logic [15:0]        BLDR_SECS_MAX      = 16'h0258;
	localparam logic [15:0]        BLDR_NOT_CONFIGURED = 16'hFFFF;
	localparam logic [15:0]        BLDR_MAP_MASK      = 16'h001F;
	localparam logic [15:0]        BLDR_FLAG_MAX      = 16'h0001;

	localparam logic [15:0] BLDR_SLOT_ADDR [0:18] = '{
		BLDR_ADDR_SLOW_START_TEMPERATURE, BLDR_ADDR_OUTLET_RISE_LIMIT_ON, BLDR_ADDR_OUTLET_RISE_RATE,
		BLDR_ADDR_OUTLET_RISE_DELAY, BLDR_ADDR_HEAT_ANTICOND_ON, BLDR_ADDR_HEAT_ANTICOND_TEMPERATURE,
		BLDR_ADDR_HEAT_ANTICOND_PUMP_OFF, BLDR_ADDR_WATER_ANTICOND_ON, BLDR_ADDR_WATER_ANTICOND_TEMPERATURE,
		BLDR_ADDR_WATER_ANTICOND_PUMP_OFF, BLDR_ADDR_ANTICOND_PRECEDENCE_MAP, BLDR_ADDR_HEAT_CURVE_OUTDOOR_HIGH,
		BLDR_ADDR_HEAT_CURVE_OUTDOOR_LOW, BLDR_ADDR_HEAT_CURVE_WATER_LOW, BLDR_ADDR_HEAT_CURVE_BOOST_TIME,
		BLDR_ADDR_HEAT_CURVE_BOOST_CEILING, BLDR_ADDR_GROUP_CURVE_OUTDOOR_HIGH, BLDR_ADDR_GROUP_CURVE_OUTDOOR_LOW,
		BLDR_ADDR_GROUP_CURVE_WATER_LOW
	};

	localparam bldr_kind_e BLDR_SLOT_KIND [0:18] = '{
		BLDR_K_TEMP, BLDR_K_FLAG, BLDR_K_RAW, BLDR_K_DELAY, BLDR_K_FLAG, BLDR_K_TEMP, BLDR_K_FLAG,
		BLDR_K_FLAG, BLDR_K_TEMP, BLDR_K_FLAG, BLDR_K_MAP, BLDR_K_TEMP, BLDR_K_TEMP, BLDR_K_TEMP,
		BLDR_K_SECS, BLDR_K_TEMP, BLDR_K_TEMP, BLDR_K_TEMP, BLDR_K_TEMP
	};

	// every word clears at reset except the rise delay, which starts unconfigured
	localparam logic [15:0] BLDR_RESET_ZERO = 16'h0000;

	// slot positions read by the control logic
	localparam int unsigned BLDR_S_SLOW   = 0;
	localparam int unsigned BLDR_S_RON    = 1;
	localparam int unsigned BLDR_S_RRATE  = 2;
	localparam int unsigned BLDR_S_RDLY   = 3;
	localparam int unsigned BLDR_S_HON    = 4;
	localparam int unsigned BLDR_S_HTEMP  = 5;
	localparam int unsigned BLDR_S_HPUMP  = 6;
	localparam int unsigned BLDR_S_WON    = 7;
	localparam int unsigned BLDR_S_WTEMP  = 8;
	localparam int unsigned BLDR_S_WPUMP  = 9;
	localparam int unsigned BLDR_S_MAP    = 10;
	localparam int unsigned BLDR_S_HCURVE = 11;
	localparam int unsigned BLDR_S_BTIME  = 14;
	localparam int unsigned BLDR_S_BCEIL  = 15;
	localparam int unsigned BLDR_S_GCURVE = 16;

	// ==========================================================
	// carriers
	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [15:0] addr;
		logic [15:0] wdata;
	} bldr_req_s;

	typedef struct packed {
		logic        ack;
		logic        refused;
		logic [15:0] rdata;
	} bldr_rsp_s;

	typedef struct packed {
		logic [15:0] outdoor_high;
		logic [15:0] outdoor_low;
		logic [15:0] water_low;
	} bldr_curve_s;

	typedef struct packed {
		logic [BLDR_SLOTS-1:0][15:0] word;
		bldr_rsp_s                   rsp;
		logic                        heat_pump;
		logic                        water_pump;
	} bldr_state_s;

endpackage

// ---- verif/bldr_config_regs_tb.sv ----
// self-checking testbench of the configuration register bank
`timescale 1ns/1ps

module bldr_config_regs_tb;
	import bldr_pkg::*;

	logic        clk_i;
	logic        reset_n_i;
	bldr_req_s   req;
	bldr_rsp_s   rsp;
	logic        heat_req, heat_act, water_req, water_act;
	logic        heat_pump, water_pump, rise_on, delay_cfg, heat_on, water_on;
	logic [15:0] slow_t, rise_rate, rise_dly, heat_t, water_t, boost_t, boost_c;
	logic [4:0]  prec;
	bldr_curve_s heat_curve, group_curve;
	logic [15:0] mdl [0:18];
	logic [15:0] corner [0:9] = '{16'h0000, 16'h0001, 16'h0002, 16'h0258, 16'h0259,
		16'h0514, 16'h0515, 16'hFE70, 16'hFE6F, 16'hFFFF};
	logic [15:0] resv [0:5] = '{16'h01E4, 16'h01EF, 16'h01F7, 16'h01FF, 16'h0208, 16'h020F};
	logic [31:0] lfsr_q;
	int          n_errors = 0;
	int          checks = 0;
	int          cycles = 0;

	bldr_master master_model (.clk_i(clk_i), .rsp_i(rsp), .req_o(req));

	bldr_config_regs DUT (
		.clk_i(clk_i), .reset_n_i(reset_n_i), .req_i(req), .rsp_o(rsp),
		.central_heat_pump_request_i(heat_req), .central_heat_anticond_active_i(heat_act),
		.domestic_hot_water_pump_request_i(water_req), .domestic_hot_water_anticond_active_i(water_act),
		.central_heat_pump_o(heat_pump), .domestic_hot_water_pump_o(water_pump),
		.slow_start_temperature_o(slow_t), .outlet_rise_limit_on_o(rise_on), .outlet_rise_rate_o(rise_rate),
		.outlet_rise_delay_o(rise_dly), .outlet_rise_delay_configured_o(delay_cfg),
		.central_heat_anticond_on_o(heat_on), .central_heat_anticond_temperature_o(heat_t),
		.domestic_hot_water_anticond_on_o(water_on), .domestic_hot_water_anticond_temperature_o(water_t),
		.anticond_precedence_o(prec), .central_heat_curve_o(heat_curve), .central_heat_boost_time_o(boost_t),
		.central_heat_boost_ceiling_o(boost_c), .group_curve_o(group_curve)
	);

	always #20 clk_i = ~clk_i;

	// ==========================================================
	// helpers
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction

	function automatic logic legal(input bldr_kind_e k, input logic [15:0] v);
		int t;
		t = $signed(v);
		case (k)
			BLDR_K_TEMP:  legal = (t >= -400) && (t <= 1300);
			BLDR_K_FLAG:  legal = (v <= 16'h0001);
			BLDR_K_SECS:  legal = (v <= 16'h0258);
			BLDR_K_DELAY: legal = (v <= 16'h0258) || (v == 16'hFFFF);
			default:      legal = 1'b1;
		endcase
	endfunction

	function automatic logic [15:0] view(input int s);
		case (s)
			0:       view = slow_t;
			1:       view = {15'h0000, rise_on};
			2:       view = rise_rate;
			3:       view = rise_dly;
			4:       view = {15'h0000, heat_on};
			5:       view = heat_t;
			7:       view = {15'h0000, water_on};
			8:       view = water_t;
			10:      view = {11'h0000, prec};
			11:      view = heat_curve.outdoor_high;
			12:      view = heat_curve.outdoor_low;
			13:      view = heat_curve.water_low;
			14:      view = boost_t;
			15:      view = boost_c;
			16:      view = group_curve.outdoor_high;
			17:      view = group_curve.outdoor_low;
			default: view = group_curve.water_low;
		endcase
	endfunction

	task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic cmp1(input logic got, input logic exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic xfer(input logic rd, input logic wr, input logic [15:0] a, input logic [15:0] d,
		output bldr_rsp_s r);
		master_model.access(rd, wr, a, d, r);
		cmp1(r.ack, 1'b1);
	endtask

	task automatic pump_phase(input logic [1:0] c);
		bldr_rsp_s  r;
		logic [3:0] p;
		xfer(1'b0, 1'b1, BLDR_ADDR_HEAT_ANTICOND_ON, {15'h0000, c[0]}, r);
		xfer(1'b0, 1'b1, BLDR_ADDR_HEAT_ANTICOND_PUMP_OFF, {15'h0000, c[1]}, r);
		xfer(1'b0, 1'b1, BLDR_ADDR_WATER_ANTICOND_ON, {15'h0000, c[0]}, r);
		xfer(1'b0, 1'b1, BLDR_ADDR_WATER_ANTICOND_PUMP_OFF, {15'h0000, c[1]}, r);
		repeat (40) begin
			@(posedge clk_i);
			p = {heat_req, heat_act, water_req, water_act};
			lfsr_q = lfsr(lfsr_q);
			{heat_req, heat_act, water_req, water_act} <= lfsr_q[3:0];
			@(negedge clk_i);
			cmp1(heat_pump, p[3] & ~(c[0] & c[1] & p[2]));
			cmp1(water_pump, p[1] & ~(c[0] & c[1] & p[0]));
		end
	endtask

	task automatic complete_run;
		if (n_errors == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// ==========================================================
	// hang guard, far above the roughly 1700 cycles the sequence needs
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			n_errors++;
			complete_run;
		end
	end

	// ==========================================================
	// main sequence
	initial begin
		bldr_rsp_s   r;
		logic [15:0] v;
		logic        ok;
		clk_i = 1'b0;
		reset_n_i = 1'b0;
		{heat_req, heat_act, water_req, water_act} = 4'h0;
		lfsr_q = 32'hb94c;
		repeat (20) @(posedge clk_i);
		reset_n_i <= 1'b1;
		@(posedge clk_i);
		for (int s = 0; s < 19; s++) begin
			mdl[s] = (s == 3) ? 16'hFFFF : 16'h0000;
			xfer(1'b1, 1'b0, BLDR_SLOT_ADDR[s], 16'h0000, r);
			cmp16(r.rdata, mdl[s]);
		end
		cmp1(delay_cfg, 1'b0);
		// boundary values of every kind plus random words, on every slot
		for (int s = 0; s < 19; s++) begin
			for (int i = 0; i < 12; i++) begin
				lfsr_q = lfsr(lfsr_q);
				v = (i < 10) ? corner[i] : lfsr_q[15:0];
				ok = legal(BLDR_SLOT_KIND[s], v);
				xfer(1'b0, 1'b1, BLDR_SLOT_ADDR[s], v, r);
				cmp1(r.refused, ~ok);
				if (ok) begin
					mdl[s] = (BLDR_SLOT_KIND[s] == BLDR_K_MAP) ? (v & 16'h001F) : v;
				end
				xfer(1'b1, 1'b0, BLDR_SLOT_ADDR[s], 16'h0000, r);
				cmp16(r.rdata, mdl[s]);
				if (s != 6 && s != 9) begin
					cmp16(view(s), mdl[s]);
				end
				cmp1(delay_cfg, mdl[3] !== 16'hFFFF);
			end
		end
		// reserved holes answer zero and keep nothing
		for (int i = 0; i < 6; i++) begin
			xfer(1'b0, 1'b1, resv[i], 16'hFFFF, r);
			cmp1(r.refused, 1'b0);
			xfer(1'b1, 1'b0, resv[i], 16'h0000, r);
			cmp16(r.rdata, 16'h0000);
		end
		// read and write together: the write is dropped
		xfer(1'b1, 1'b1, BLDR_ADDR_SLOW_START_TEMPERATURE, 16'h0005, r);
		cmp16(r.rdata, mdl[0]);
		cmp16(slow_t, mdl[0]);
		for (int c = 0; c < 4; c++) begin
			pump_phase(c[1:0]);
		end
		complete_run;
	end
endmodule

// ---- verif/bldr_master.sv ----
// register master model that issues one access at a time (read, write or both together) to the configuration bank
`timescale 1ns/1ps

module bldr_master
	import bldr_pkg::*;
(
	input  wire logic                clk_i,
	input  wire bldr_pkg::bldr_rsp_s rsp_i,
	output bldr_pkg::bldr_req_s      req_o
);
	import bldr_pkg::*;

	initial req_o = '0;

	// ==========================================================
	// one access: request held one cycle, answer taken at the ack edge
	task automatic access(input logic rd, input logic wr, input logic [15:0] addr, input logic [15:0] wdata,
		output bldr_rsp_s rsp);
		@(posedge clk_i);
		req_o <= '{rd: rd, wr: wr, addr: addr, wdata: wdata};
		@(posedge clk_i);
		// released lines show the inverse so a stale value is never mistaken for a live one
		req_o <= '{rd: 1'b0, wr: 1'b0, addr: ~addr, wdata: ~wdata};
		@(posedge clk_i);
		rsp = rsp_i;
	endtask
endmodule
